// File: dv/llmc_far_end.sv
// Far-end line equipment model sending a repeated inband code on all channels.
`timescale 1ns/1ps
module llmc_far_end (
	input  wire       clock_in,
	input  wire       send_in,
	input  wire [7:0] code_in,
	input  wire [3:0] code_len_in,
	output reg  [3:0] rec_clock_out = 4'h0,
	output reg  [3:0] rec_pos_out   = 4'h0,
	output reg  [3:0] rec_neg_out   = 4'h0,
	output reg  [3:0] bit_valid_out = 4'h0
);
	reg [2:0] phase   = 3'h0;
	reg [2:0] bit_idx = 3'h0;
	// One code bit every eight master clocks gives the 160 ns line bit time.
	always @(posedge clock_in)
	begin
		phase         <= send_in ? phase + 3'h1 : 3'h0;
		bit_valid_out <= {4{send_in && phase == 3'h0}};
		rec_clock_out <= {4{send_in && !phase[2]}};
		if (!send_in)
		begin
			// Idle data keeps changing so that nothing stale can pass for a code.
			rec_pos_out <= ~rec_pos_out;
			rec_neg_out <= ~rec_neg_out;
			bit_idx     <= 3'h0;
		end
		else if (phase == 3'h0)
		begin
			rec_pos_out <= {4{code_in[3'h7 - bit_idx]}};
			rec_neg_out <= 4'h0;
			bit_idx     <= (bit_idx == code_len_in[2:0] - 3'h1) ? 3'h0 : bit_idx + 3'h1;
		end
	end
endmodule // llmc_far_end

// File: dv/llmc_loop_ctrl_properties.sv
// Concurrent checks on the loop maintenance control ports.
`timescale 1ns/1ps
`include "llmc_defines.vh"
module llmc_loop_ctrl_properties #(
	parameter NCH = 4
) (
	input wire           clock_in,
	input wire           rst_b_in,
	input wire           host_mode_in,
	input wire [4:0]     addr_in,
	input wire [7:0]     wdata_in,
	input wire           wr_in,
	input wire [NCH-1:0] loop_select_pin_in,
	input wire [NCH-1:0] transmit_clock_pin_in,
	input wire           mclk_held_low_in,
	input wire [NCH-1:0] tx_power_down_out,
	input wire [NCH-1:0] rx_power_down_out,
	input wire [NCH-1:0] remote_loop_active_out,
	input wire           monitor_active_out,
	input wire [1:0]     monitor_channel_out,
	input wire           internal_reset_out
);
	// Saturates so that a pin parked low for a long time never wraps back below the limit.
	reg [7:0] low_run;
	always @(posedge clock_in)
	begin
		if (!rst_b_in || transmit_clock_pin_in[0])
			low_run <= 8'h00;
		else if (low_run != 8'hFF)
			low_run <= low_run + 8'h01;
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	property p_por;
		$rose(rst_b_in) |-> internal_reset_out [*4];
	endproperty
	a_por: assert property (p_por) else $error("power-on reset too short");
	property p_soft;
		wr_in && addr_in == `LLMC_ADDR_SOFT_RESET && !internal_reset_out
			|-> ##[1:2] internal_reset_out [*8];
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset not started");
	property p_soft_len;
		$rose(internal_reset_out) |-> ##[45:55] !internal_reset_out;
	endproperty
	a_soft_len: assert property (p_soft_len) else $error("soft reset length off");
	property p_txpd_pin;
		$rose(tx_power_down_out[0]) && !host_mode_in |-> low_run >= 8'd64;
	endproperty
	a_txpd_pin: assert property (p_txpd_pin) else $error("early power down");
	property p_txpd_reg;
		host_mode_in && wr_in && addr_in == `LLMC_ADDR_TX_POWER_DOWN && wdata_in[1]
			&& !internal_reset_out |-> ##[1:2] tx_power_down_out[1];
	endproperty
	a_txpd_reg: assert property (p_txpd_reg) else $error("tx power down bit ignored");
	property p_rx_mclk;
		mclk_held_low_in [*3] |-> rx_power_down_out == {NCH{1'b1}};
	endproperty
	a_rx_mclk: assert property (p_rx_mclk) else $error("receivers still powered");
	property p_mon;
		monitor_active_out |-> monitor_channel_out != 2'b00;
	endproperty
	a_mon: assert property (p_mon) else $error("channel 0 monitoring itself");
	property p_hw_loop;
		(!host_mode_in && !loop_select_pin_in[2] && !internal_reset_out) [*6]
			|-> remote_loop_active_out[2];
	endproperty
	a_hw_loop: assert property (p_hw_loop) else $error("loop pin ignored");
endmodule // llmc_loop_ctrl_properties

bind llmc_loop_ctrl llmc_loop_ctrl_properties #(.NCH(NCH)) u_llmc_loop_ctrl_properties (
	.clock_in, .rst_b_in, .host_mode_in, .addr_in, .wdata_in, .wr_in, .loop_select_pin_in,
	.transmit_clock_pin_in, .mclk_held_low_in, .tx_power_down_out, .rx_power_down_out,
	.remote_loop_active_out, .monitor_active_out, .monitor_channel_out, .internal_reset_out);

// File: dv/llmc_loop_ctrl_tb_top.sv
// Self-checking testbench for the loop maintenance control block.
`timescale 1ns/1ps
module llmc_loop_ctrl_tb_top;
	reg        clock_in = 1'b0, rst_b_in = 1'b0, host_mode_in = 1'b1, link_clk = 1'b0;
	reg        wr_in = 1'b0, rd_in = 1'b0, mclk_held_low_in = 1'b0, send = 1'b0;
	reg  [4:0] addr_in = 5'h00;
	reg  [7:0] wdata_in = 8'h00, code = 8'hC6;
	reg  [3:0] loop_select_pin_in = 4'hF, monitor_select_pins_in = 4'h0, txclk_run = 4'hF;
	reg  [3:0] transmit_data_pos_in = 4'h0, transmit_violation_neg_in = 4'h0, txclk_lvl = 4'h0;
	reg  [3:0] jitter_attenuator_en_in = 4'h0, loss_of_signal_in = 4'h0;
	wire [3:0] transmit_clock_pin_in, rec_clock_in, rec_data_pos_in, rec_data_neg_in;
	wire [3:0] jitter_clock_in, jitter_data_pos_in, jitter_data_neg_in, code_bit_valid_in;
	wire [3:0] receive_clock_out, receive_data_pos_out, receive_violation_neg_out;
	wire [3:0] line_tx_pos_out, line_tx_neg_out, line_tx_clock_out, tx_power_down_out;
	wire [3:0] rx_power_down_out, remote_loop_active_out;
	wire [7:0] rdata_out;
	wire [1:0] monitor_channel_out;
	wire       monitor_active_out, monitor_tx_path_out, irq_out, internal_reset_out;
	integer    error_cnt = 0, check_count = 0;
	// The jitter path carries inverted data so that its selection shows on the line.
	assign jitter_clock_in       = rec_clock_in;
	assign jitter_data_pos_in    = ~rec_data_pos_in;
	assign jitter_data_neg_in    = rec_data_neg_in;
	assign transmit_clock_pin_in = (txclk_run & {4{link_clk}}) | (~txclk_run & txclk_lvl);
	llmc_loop_ctrl #(.CODE_HOLD_CYCLES(20), .POR_CYCLES(8)) u_llmc_loop_ctrl (
		.clock_in, .rst_b_in, .host_mode_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.loop_select_pin_in, .monitor_select_pins_in, .transmit_clock_pin_in,
		.transmit_data_pos_in, .transmit_violation_neg_in, .jitter_attenuator_en_in,
		.rec_clock_in, .rec_data_pos_in, .rec_data_neg_in, .jitter_clock_in,
		.jitter_data_pos_in, .jitter_data_neg_in, .loss_of_signal_in, .code_bit_valid_in,
		.mclk_held_low_in, .receive_clock_out, .receive_data_pos_out,
		.receive_violation_neg_out, .line_tx_pos_out, .line_tx_neg_out, .line_tx_clock_out,
		.tx_power_down_out, .rx_power_down_out, .remote_loop_active_out, .monitor_active_out,
		.monitor_channel_out, .monitor_tx_path_out, .irq_out, .internal_reset_out);
	llmc_far_end u_llmc_far_end (.clock_in, .send_in(send), .code_in(code), .code_len_in(4'd5),
		.rec_clock_out(rec_clock_in), .rec_pos_out(rec_data_pos_in),
		.rec_neg_out(rec_data_neg_in), .bit_valid_out(code_bit_valid_in));
	initial
		forever #10 clock_in = ~clock_in;
	initial
		#7 forever #80 link_clk = ~link_clk;
	task summarize;
		begin
			$display("checks %0d mismatches %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input [7:0] g, input [7:0] e, input string s);
		begin
			check_count = check_count + 1;
			if (g !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("wrong value at %0t: %s", $time, s);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clock_in);
			#1;
		end
	endtask
	task wr(input [4:0] a, input [7:0] d);
		begin
			@(posedge clock_in);
			wr_in    <= 1'b1;
			addr_in  <= a;
			wdata_in <= d;
			@(posedge clock_in);
			wr_in <= 1'b0;
		end
	endtask
	task rchk(input [4:0] a, input [7:0] m, input [7:0] e, input string s);
		begin
			@(posedge clock_in);
			rd_in   <= 1'b1;
			addr_in <= a;
			@(posedge clock_in);
			rd_in <= 1'b0;
			#1;
			chk(rdata_out & m, e, s);
		end
	endtask
	// Bounded wait on loop state, interrupt, internal reset or code bit strobe.
	task wait_for(input integer k, input [3:0] v);
		integer n;
		begin
			n = 0;
			while (((k == 0) ? remote_loop_active_out : (k == 1) ? {3'b000, irq_out} :
				(k == 2) ? {3'b000, internal_reset_out} : {3'b000, code_bit_valid_in[0]})
				!== v && n < 3000)
			begin
				@(posedge clock_in);
				#1;
				n = n + 1;
			end
			if (n >= 3000)
				chk(8'h00, 8'h01, "wait limit");
		end
	endtask
	task t_regs;
		reg [24:0] tbl;
		reg [4:0]  a;
		integer    i;
		begin
			tbl = {5'h08, 5'h09, 5'h0A, 5'h0E, 5'h0F};
			for (i = 0; i < 5; i = i + 1)
			begin
				a = tbl[i*5 +: 5];
				rchk(a, 8'hFF, 8'h00, "reset value");
				wr(a, (a == 5'h08) ? 8'h0C : 8'hA5);
				rchk(a, 8'hFF, (a == 5'h08) ? 8'h0C : 8'hA5, "readback");
				wr(a, 8'h00);
			end
			rchk(5'h1B, 8'hFF, 8'h00, "unmapped read");
			$display("test regs done");
		end
	endtask
	task t_remote;
		integer i;
		begin
			send                 <= 1'b1;
			transmit_data_pos_in <= 4'hF;
			wr(5'h03, 8'h01);
			rchk(5'h12, 8'h0F, 8'h01, "remote state");
			wait_for(3, 4'h1);
			cyc(4);
			for (i = 0; i < 10; i = i + 1)
			begin
				jitter_attenuator_en_in <= (i >= 4) ? 4'h1 : 4'h0;
				chk({7'h00, line_tx_pos_out[0]}, {7'h00, rec_data_pos_in[0] ^ (i > 4)}, "line");
				chk({7'h00, receive_data_pos_out[0]}, {7'h00, rec_data_pos_in[0]}, "rx out");
				cyc(8);
			end
			jitter_attenuator_en_in <= 4'h0;
			send                    <= 1'b0;
			$display("test remote done");
		end
	endtask
	task t_dual_ones_reset;
		begin
			wr(5'h02, 8'h02);
			wr(5'h03, 8'h03);
			transmit_data_pos_in <= 4'h2;
			cyc(6);
			chk({7'h00, receive_data_pos_out[1]}, 8'h01, "dual high");
			transmit_data_pos_in <= 4'h0;
			cyc(6);
			chk({7'h00, receive_data_pos_out[1]}, 8'h00, "dual low");
			wr(5'h04, 8'h08);
			wr(5'h05, 8'h04);
			rchk(5'h12, 8'hFF, 8'h83, "all ones");
			loss_of_signal_in <= 4'h4;
			cyc(4);
			rchk(5'h12, 8'hFF, 8'hC3, "auto all ones");
			wr(5'h07, 8'h00);
			// Lands inside the internal reset and must be dropped.
			wr(5'h03, 8'h01);
			chk({7'h00, internal_reset_out}, 8'h01, "soft reset");
			wait_for(2, 4'h0);
			loss_of_signal_in <= 4'h0;
			rchk(5'h12, 8'hFF, 8'h00, "defaults");
			rchk(5'h03, 8'hFF, 8'h00, "write in reset");
			$display("test dual done");
		end
	endtask
	task t_inband;
		begin
			wr(5'h09, 8'hC6);
			wr(5'h0A, 8'hE7);
			wr(5'h0D, 8'h0F);
			wr(5'h08, 8'h10);
			send <= 1'b1;
			wait_for(1, 4'h1);
			chk({7'h00, irq_out}, 8'h01, "irq");
			chk({4'h0, remote_loop_active_out}, 8'h00, "no auto");
			rchk(5'h0B, 8'hFF, 8'h0F, "status");
			cyc(2);
			chk({7'h00, irq_out}, 8'h00, "irq clear");
			wr(5'h08, 8'h30);
			wait_for(0, 4'hF);
			chk({4'h0, remote_loop_active_out}, 8'h0F, "loop up");
			code <= 8'hE7;
			cyc(10);
			chk({4'h0, remote_loop_active_out}, 8'h0F, "early down");
			wait_for(0, 4'h0);
			chk({4'h0, remote_loop_active_out}, 8'h00, "loop down");
			send <= 1'b0;
			wr(5'h08, 8'h00);
			wr(5'h0E, 8'h00);
			wr(5'h0F, 8'h02);
			rchk(5'h0F, 8'hFF, 8'h02, "generator");
			wr(5'h0F, 8'h00);
			$display("test inband done");
		end
	endtask
	task t_hw_power;
		begin
			host_mode_in       <= 1'b0;
			loop_select_pin_in <= 4'hB;
			txclk_run          <= 4'h6;
			txclk_lvl          <= 4'h8;
			cyc(30);
			chk({4'h0, remote_loop_active_out}, 8'h04, "loop pin");
			rchk(5'h12, 8'hF0, 8'h80, "pin all ones");
			chk({4'h0, tx_power_down_out}, 8'h00, "early pd");
			cyc(60);
			chk({4'h0, tx_power_down_out}, 8'h01, "pin pd");
			txclk_run <= 4'hF;
			cyc(10);
			chk({4'h0, tx_power_down_out}, 8'h00, "pd clear");
			monitor_select_pins_in <= 4'hE;
			cyc(8);
			chk({4'h0, monitor_active_out, monitor_tx_path_out, monitor_channel_out},
				8'h0E, "monitor");
			mclk_held_low_in <= 1'b1;
			cyc(5);
			chk({4'h0, rx_power_down_out}, 8'h0F, "mclk low");
			mclk_held_low_in <= 1'b0;
			host_mode_in     <= 1'b1;
			wr(5'h11, 8'h01);
			wr(5'h10, 8'h02);
			cyc(3);
			chk({tx_power_down_out, rx_power_down_out}, 8'h21, "pd bits");
			$display("test hw done");
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_b_in <= 1'b1;
		cyc(2);
		wait_for(2, 4'h0);
		t_regs;
		t_remote;
		t_dual_ones_reset;
		t_inband;
		t_hw_power;
		summarize;
	end
	initial
	begin
		#400000;
		error_cnt = error_cnt + 1;
		summarize;
	end
endmodule // llmc_loop_ctrl_tb_top

// File: logic/llmc_defines.vh
// Register offsets, field positions, reset values and timing counts for loop maintenance.
`ifndef LLMC_DEFINES_VH
`define LLMC_DEFINES_VH
`define LLMC_ADDR_DIGITAL_LOOP   5'h02
`define LLMC_ADDR_REMOTE_LOOP    5'h03
`define LLMC_ADDR_ALL_ONES       5'h04
`define LLMC_ADDR_AUTO_ALL_ONES  5'h05
`define LLMC_ADDR_MONITOR        5'h06
`define LLMC_ADDR_SOFT_RESET     5'h07
`define LLMC_ADDR_CODE_CONFIG    5'h08
`define LLMC_ADDR_ACT_PATTERN    5'h09
`define LLMC_ADDR_DEACT_PATTERN  5'h0A
`define LLMC_ADDR_STATUS         5'h0B
`define LLMC_ADDR_IRQ_STATUS     5'h0C
`define LLMC_ADDR_IRQ_MASK       5'h0D
`define LLMC_ADDR_GEN_SELECT     5'h0E
`define LLMC_ADDR_GEN_ENABLE     5'h0F
`define LLMC_ADDR_TX_POWER_DOWN  5'h10
`define LLMC_ADDR_RX_POWER_DOWN  5'h11
`define LLMC_ADDR_CHAN_STATE     5'h12
`define LLMC_CFG_DEACT_LEN_LSB   0
`define LLMC_CFG_ACT_LEN_LSB     2
`define LLMC_CFG_DETECT_EN_BIT   4
`define LLMC_CFG_AUTO_LOOP_BIT   5
`define LLMC_RESET_VALUE         8'h00
`define LLMC_CLK_PERIOD_NS       20
`define LLMC_TX_HIGH_CYCLES      16
`define LLMC_TX_LOW_CYCLES       64
`define LLMC_SOFT_RESET_NS       1000
`define LLMC_POR_NS              10000
`define LLMC_CODE_HOLD_MS        5100
`endif

// File: logic/llmc_loop_ctrl.v
// Per-channel loopback, all-ones, inband code, monitoring, reset and power-down control.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "llmc_defines.vh"
module llmc_loop_ctrl #(
	parameter CODE_HOLD_CYCLES = 255000000,
	parameter POR_CYCLES       = (`LLMC_POR_NS + `LLMC_CLK_PERIOD_NS - 1) / `LLMC_CLK_PERIOD_NS,
	parameter NCH              = 4
) (
	input  wire           clock_in,
	input  wire           rst_b_in,
	input  wire           host_mode_in,
	input  wire [4:0]     addr_in,
	input  wire [7:0]     wdata_in,
	input  wire           wr_in,
	input  wire           rd_in,
	output reg  [7:0]     rdata_out,
	input  wire [NCH-1:0] loop_select_pin_in,
	input  wire [3:0]     monitor_select_pins_in,
	input  wire [NCH-1:0] transmit_clock_pin_in,
	input  wire [NCH-1:0] transmit_data_pos_in,
	input  wire [NCH-1:0] transmit_violation_neg_in,
	input  wire [NCH-1:0] jitter_attenuator_en_in,
	input  wire [NCH-1:0] rec_clock_in,
	input  wire [NCH-1:0] rec_data_pos_in,
	input  wire [NCH-1:0] rec_data_neg_in,
	input  wire [NCH-1:0] jitter_clock_in,
	input  wire [NCH-1:0] jitter_data_pos_in,
	input  wire [NCH-1:0] jitter_data_neg_in,
	input  wire [NCH-1:0] loss_of_signal_in,
	input  wire [NCH-1:0] code_bit_valid_in,
	input  wire           mclk_held_low_in,
	output reg  [NCH-1:0] receive_clock_out,
	output reg  [NCH-1:0] receive_data_pos_out,
	output reg  [NCH-1:0] receive_violation_neg_out,
	output reg  [NCH-1:0] line_tx_pos_out,
	output reg  [NCH-1:0] line_tx_neg_out,
	output reg  [NCH-1:0] line_tx_clock_out,
	output reg  [NCH-1:0] tx_power_down_out,
	output reg  [NCH-1:0] rx_power_down_out,
	output reg  [NCH-1:0] remote_loop_active_out,
	output reg            monitor_active_out,
	output reg  [1:0]     monitor_channel_out,
	output reg            monitor_tx_path_out,
	output reg            irq_out,
	output reg            internal_reset_out
);
	localparam SR_CYCLES = `LLMC_SOFT_RESET_NS / `LLMC_CLK_PERIOD_NS;
	localparam RCW = 16;

	reg [7:0] digital_loop_reg;
	reg [7:0] remote_loop_reg;
	reg [7:0] all_ones_reg;
	reg [7:0] auto_all_ones_reg;
	reg [7:0] monitor_select_reg;
	reg [7:0] inband_code_config;
	reg [7:0] inband_activate_pattern;
	reg [7:0] inband_deactivate_pattern;
	reg [7:0] inband_irq_status;
	reg [7:0] inband_irq_mask;
	reg [7:0] inband_generator_select;
	reg [7:0] inband_generator_enable;
	reg [7:0] tx_power_down_reg;
	reg [7:0] rx_power_down_reg;
	reg [NCH-1:0] inband_status;
	reg [NCH-1:0] auto_loop;
	reg [NCH-1:0] tc_s1, tc_s2, tc_s3;
	reg [NCH-1:0] ld_s1, ld_s2, ld_s3;
	reg [3:0] mc_s1, mc_s2, mc_s3;
	reg [NCH-1:0] transmit_all_ones;
	reg [NCH-1:0] tx_clock_dead;
	reg [NCH-1:0] gen_bit;
	reg [RCW-1:0] reset_count;
	reg           por_done;
	reg [3:0]     mc_q;
	reg [NCH-1:0] ld_q;

	wire          detect_en = inband_code_config[`LLMC_CFG_DETECT_EN_BIT];
	wire          auto_en   = inband_code_config[`LLMC_CFG_AUTO_LOOP_BIT];
	wire [1:0]    act_len   = inband_code_config[`LLMC_CFG_ACT_LEN_LSB +: 2];
	wire [1:0]    deact_len = inband_code_config[`LLMC_CFG_DEACT_LEN_LSB +: 2];
	wire          regs_rst  = ~rst_b_in | internal_reset_out;
	wire [NCH-1:0] remote_loop;
	wire [NCH-1:0] status_chg;
	reg  [NCH-1:0] status_d;

	// Soft reset and power-on reset share one counter; writing the reset register loads it only while no internal reset is running.
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			reset_count        <= {RCW{1'b0}};
			por_done           <= 1'b0;
			internal_reset_out <= 1'b1;
		end
		else if (!por_done)
		begin
			reset_count        <= reset_count + 1'b1;
			internal_reset_out <= 1'b1;
			if (reset_count == POR_CYCLES[RCW-1:0] - 1'b1)
			begin
				por_done    <= 1'b1;
				reset_count <= {RCW{1'b0}};
			end
		end
		else if (wr_in && addr_in == `LLMC_ADDR_SOFT_RESET && !internal_reset_out)
		begin
			reset_count        <= SR_CYCLES[RCW-1:0];
			internal_reset_out <= 1'b1;
		end
		else if (reset_count != {RCW{1'b0}})
		begin
			reset_count        <= reset_count - 1'b1;
			internal_reset_out <= (reset_count != 16'h0001);
		end
		else
			internal_reset_out <= 1'b0;
	end

	// Pins from outside the clock domain; a change counts once stages two and three agree.
	always @(posedge clock_in)
	begin
		tc_s1 <= transmit_clock_pin_in;
		tc_s2 <= tc_s1;
		tc_s3 <= tc_s2;
		ld_s1 <= loop_select_pin_in;
		ld_s2 <= ld_s1;
		ld_s3 <= ld_s2;
		mc_s1 <= monitor_select_pins_in;
		mc_s2 <= mc_s1;
		mc_s3 <= mc_s2;
		if (!rst_b_in)
		begin
			ld_q <= {NCH{1'b1}};
			mc_q <= 4'h0;
		end
		else
		begin
			if (ld_s2 == ld_s3)
				ld_q <= ld_s3;
			if (mc_s2 == mc_s3)
				mc_q <= mc_s3;
		end
	end

	assign status_chg = inband_status ^ status_d;
	assign remote_loop = host_mode_in ? (remote_loop_reg[NCH-1:0] | auto_loop)
		: ~ld_q;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch = ch + 1)
		begin : g_ch
			reg [6:0]     high_cnt;
			reg [6:0]     low_cnt;
			reg           tc_q;
			reg [7:0]     shift;
			reg           act_on;
			reg           deact_on;
			reg [2:0]     act_gap;
			reg [2:0]     deact_gap;
			reg [31:0]    hold_cnt;
			reg           hold_act;
			reg [2:0]     gen_pos;
			wire [2:0]    alen = {1'b0, act_len} + 3'd5;
			wire [2:0]    dlen = {1'b0, deact_len} + 3'd5;
			wire [7:0]    amask = 8'hFF << (3'd0 - alen);
			wire [7:0]    dmask = 8'hFF << (3'd0 - dlen);
			wire          act_hit = ((shift ^ inband_activate_pattern) & amask) == 8'h00;
			wire          deact_hit = ((shift ^ inband_deactivate_pattern) & dmask) == 8'h00;
			wire          gen_act = ~inband_generator_select[ch];
			wire [2:0]    glen = gen_act ? alen : dlen;
			wire [7:0]    gpat = gen_act ? inband_activate_pattern : inband_deactivate_pattern;

			// Pin duration counters restart on every settled toggle.
			always @(posedge clock_in)
			begin
				if (!rst_b_in)
				begin
					tc_q     <= 1'b0;
					high_cnt <= 7'h00;
					low_cnt  <= 7'h00;
					transmit_all_ones[ch] <= 1'b0;
					tx_clock_dead[ch]     <= 1'b0;
				end
				else
				begin
					if (tc_s2[ch] == tc_s3[ch])
						tc_q <= tc_s3[ch];
					if (tc_q != tc_s3[ch] && tc_s2[ch] == tc_s3[ch])
					begin
						high_cnt <= 7'h00;
						low_cnt  <= 7'h00;
					end
					else if (tc_q)
					begin
						if (high_cnt <= `LLMC_TX_HIGH_CYCLES)
							high_cnt <= high_cnt + 1'b1;
					end
					else if (low_cnt <= `LLMC_TX_LOW_CYCLES)
						low_cnt <= low_cnt + 1'b1;
					transmit_all_ones[ch] <= host_mode_in ? (all_ones_reg[ch]
						| (auto_all_ones_reg[ch] & loss_of_signal_in[ch]))
						: (tc_q && high_cnt > `LLMC_TX_HIGH_CYCLES);
					tx_clock_dead[ch] <= ~tc_q && low_cnt > `LLMC_TX_LOW_CYCLES;
				end
			end

			// Inband code detector, shared settings for every channel, plus generator.
			always @(posedge clock_in)
			begin
				if (regs_rst)
				begin
					shift         <= 8'h00;
					act_on        <= 1'b0;
					deact_on      <= 1'b0;
					act_gap       <= 3'd7;
					deact_gap     <= 3'd7;
					hold_cnt      <= 32'h0;
					hold_act      <= 1'b0;
					auto_loop[ch] <= 1'b0;
					inband_status[ch] <= 1'b0;
					gen_pos       <= 3'd0;
					gen_bit[ch]   <= 1'b0;
				end
				else
				begin
					if (code_bit_valid_in[ch])
					begin
						shift <= {shift[6:0], rec_data_pos_in[ch]};
						if (inband_generator_enable[ch])
						begin
							gen_bit[ch] <= gpat[3'd7 - gen_pos];
							gen_pos <= (gen_pos == glen - 3'd1) ? 3'd0 : gen_pos + 3'd1;
						end
					end
					if (!inband_generator_enable[ch])
						gen_pos <= 3'd0;
					if (!detect_en)
					begin
						hold_cnt <= 32'h0;
						inband_status[ch] <= 1'b0;
					end
					else if (code_bit_valid_in[ch])
					begin
						// A code counts as present only while its window recurs every length bits.
						act_on <= act_hit ? (act_gap == alen - 3'd1)
							: act_on & (act_gap < alen - 3'd1);
						act_gap <= act_hit ? 3'd0 : act_gap + {2'b00, act_gap != 3'd7};
						deact_on <= deact_hit ? (deact_gap == dlen - 3'd1)
							: deact_on & (deact_gap < dlen - 3'd1);
						deact_gap <= deact_hit ? 3'd0 : deact_gap + {2'b00, deact_gap != 3'd7};
						if ((act_on | deact_on) && hold_act == act_on)
						begin
							if (hold_cnt < CODE_HOLD_CYCLES)
								hold_cnt <= hold_cnt + 1'b1;
						end
						else
						begin
							hold_act <= act_on;
							hold_cnt <= (act_on | deact_on) ? 32'h1 : 32'h0;
						end
						inband_status[ch] <= act_on | deact_on;
					end
					else if (hold_cnt != 32'h0 && hold_cnt < CODE_HOLD_CYCLES)
						hold_cnt <= hold_cnt + 1'b1;
					if (detect_en && auto_en && hold_cnt >= CODE_HOLD_CYCLES)
						auto_loop[ch] <= hold_act;
				end
			end

			// Data routing per channel; the digital loop needs the remote loop enabled as well.
			always @(posedge clock_in)
			begin
				if (!rst_b_in)
				begin
					receive_clock_out[ch]         <= 1'b0;
					receive_data_pos_out[ch]      <= 1'b0;
					receive_violation_neg_out[ch] <= 1'b0;
					line_tx_pos_out[ch]           <= 1'b0;
					line_tx_neg_out[ch]           <= 1'b0;
					line_tx_clock_out[ch]         <= 1'b0;
					tx_power_down_out[ch]         <= 1'b0;
					rx_power_down_out[ch]         <= 1'b0;
					remote_loop_active_out[ch]    <= 1'b0;
				end
				else
				begin
					remote_loop_active_out[ch] <= remote_loop[ch];
					tx_power_down_out[ch] <= tx_clock_dead[ch]
						| (host_mode_in & tx_power_down_reg[ch]);
					rx_power_down_out[ch] <= mclk_held_low_in | rx_power_down_reg[ch];
					if (digital_loop_reg[ch] && remote_loop[ch])
					begin
						receive_clock_out[ch]         <= transmit_clock_pin_in[ch];
						receive_data_pos_out[ch]      <= transmit_data_pos_in[ch];
						receive_violation_neg_out[ch] <= transmit_violation_neg_in[ch];
					end
					else
					begin
						receive_clock_out[ch]         <= rec_clock_in[ch];
						receive_data_pos_out[ch]      <= rec_data_pos_in[ch];
						receive_violation_neg_out[ch] <= rec_data_neg_in[ch];
					end
					if (remote_loop[ch])
					begin
						line_tx_clock_out[ch] <= jitter_attenuator_en_in[ch]
							? jitter_clock_in[ch] : rec_clock_in[ch];
						line_tx_pos_out[ch] <= jitter_attenuator_en_in[ch]
							? jitter_data_pos_in[ch] : rec_data_pos_in[ch];
						line_tx_neg_out[ch] <= jitter_attenuator_en_in[ch]
							? jitter_data_neg_in[ch] : rec_data_neg_in[ch];
					end
					else if (transmit_all_ones[ch])
					begin
						line_tx_clock_out[ch] <= ~line_tx_clock_out[ch];
						line_tx_pos_out[ch]   <= ~line_tx_clock_out[ch] & ~line_tx_neg_out[ch];
						line_tx_neg_out[ch]   <= ~line_tx_clock_out[ch] & line_tx_neg_out[ch];
					end
					else
					begin
						line_tx_clock_out[ch] <= transmit_clock_pin_in[ch];
						line_tx_pos_out[ch]   <= inband_generator_enable[ch]
							? gen_bit[ch] : transmit_data_pos_in[ch];
						line_tx_neg_out[ch]   <= inband_generator_enable[ch]
							? 1'b0 : transmit_violation_neg_in[ch];
					end
				end
			end
		end
	endgenerate

	// Monitor select: bit 3 enables, bit 2 picks transmit path, bits 1:0 the channel.
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			monitor_active_out  <= 1'b0;
			monitor_channel_out <= 2'h0;
			monitor_tx_path_out <= 1'b0;
		end
		else
		begin
			monitor_active_out  <= host_mode_in ? monitor_select_reg[3] : mc_q[3];
			monitor_channel_out <= host_mode_in ? monitor_select_reg[1:0] : mc_q[1:0];
			monitor_tx_path_out <= host_mode_in ? monitor_select_reg[2] : mc_q[2];
		end
	end

	// Register writes, interrupt latch; a status change wins over the clear on read.
	always @(posedge clock_in)
	begin
		if (regs_rst)
		begin
			digital_loop_reg          <= `LLMC_RESET_VALUE;
			remote_loop_reg           <= `LLMC_RESET_VALUE;
			all_ones_reg              <= `LLMC_RESET_VALUE;
			auto_all_ones_reg         <= `LLMC_RESET_VALUE;
			monitor_select_reg        <= `LLMC_RESET_VALUE;
			inband_code_config        <= `LLMC_RESET_VALUE;
			inband_activate_pattern   <= `LLMC_RESET_VALUE;
			inband_deactivate_pattern <= `LLMC_RESET_VALUE;
			inband_irq_status         <= `LLMC_RESET_VALUE;
			inband_irq_mask           <= `LLMC_RESET_VALUE;
			inband_generator_select   <= `LLMC_RESET_VALUE;
			inband_generator_enable   <= `LLMC_RESET_VALUE;
			tx_power_down_reg         <= `LLMC_RESET_VALUE;
			rx_power_down_reg         <= `LLMC_RESET_VALUE;
			irq_out                   <= 1'b0;
		end
		else
		begin
			if (wr_in)
			begin
				if (addr_in == `LLMC_ADDR_DIGITAL_LOOP)
					digital_loop_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_REMOTE_LOOP)
					remote_loop_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_ALL_ONES)
					all_ones_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_AUTO_ALL_ONES)
					auto_all_ones_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_MONITOR)
					monitor_select_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_CODE_CONFIG)
					inband_code_config <= wdata_in;
				else if (addr_in == `LLMC_ADDR_ACT_PATTERN)
					inband_activate_pattern <= wdata_in;
				else if (addr_in == `LLMC_ADDR_DEACT_PATTERN)
					inband_deactivate_pattern <= wdata_in;
				else if (addr_in == `LLMC_ADDR_IRQ_MASK)
					inband_irq_mask <= wdata_in;
				else if (addr_in == `LLMC_ADDR_GEN_SELECT)
					inband_generator_select <= wdata_in;
				else if (addr_in == `LLMC_ADDR_GEN_ENABLE)
					inband_generator_enable <= wdata_in;
				else if (addr_in == `LLMC_ADDR_TX_POWER_DOWN)
					tx_power_down_reg <= wdata_in;
				else if (addr_in == `LLMC_ADDR_RX_POWER_DOWN)
					rx_power_down_reg <= wdata_in;
			end
			inband_irq_status <= ((rd_in && addr_in == `LLMC_ADDR_STATUS)
				? 8'h00 : inband_irq_status)
				| {{(8-NCH){1'b0}}, status_chg & inband_irq_mask[NCH-1:0]};
			irq_out <= |(inband_irq_status & inband_irq_mask);
		end
	end

	always @(posedge clock_in)
	begin
		if (regs_rst)
			status_d <= {NCH{1'b0}};
		else
			status_d <= inband_status;
	end

	// Read data appear in the cycle after the strobe; unmapped addresses read zero.
	always @(posedge clock_in)
	begin
		if (!rst_b_in)
			rdata_out <= 8'h00;
		else if (!rd_in)
			rdata_out <= 8'h00;
		else if (addr_in == `LLMC_ADDR_DIGITAL_LOOP)
			rdata_out <= digital_loop_reg;
		else if (addr_in == `LLMC_ADDR_REMOTE_LOOP)
			rdata_out <= remote_loop_reg;
		else if (addr_in == `LLMC_ADDR_ALL_ONES)
			rdata_out <= all_ones_reg;
		else if (addr_in == `LLMC_ADDR_AUTO_ALL_ONES)
			rdata_out <= auto_all_ones_reg;
		else if (addr_in == `LLMC_ADDR_MONITOR)
			rdata_out <= monitor_select_reg;
		else if (addr_in == `LLMC_ADDR_CODE_CONFIG)
			rdata_out <= inband_code_config;
		else if (addr_in == `LLMC_ADDR_ACT_PATTERN)
			rdata_out <= inband_activate_pattern;
		else if (addr_in == `LLMC_ADDR_DEACT_PATTERN)
			rdata_out <= inband_deactivate_pattern;
		else if (addr_in == `LLMC_ADDR_STATUS)
			rdata_out <= {{(8-NCH){1'b0}}, inband_status};
		else if (addr_in == `LLMC_ADDR_IRQ_STATUS)
			rdata_out <= inband_irq_status;
		else if (addr_in == `LLMC_ADDR_IRQ_MASK)
			rdata_out <= inband_irq_mask;
		else if (addr_in == `LLMC_ADDR_GEN_SELECT)
			rdata_out <= inband_generator_select;
		else if (addr_in == `LLMC_ADDR_GEN_ENABLE)
			rdata_out <= inband_generator_enable;
		else if (addr_in == `LLMC_ADDR_TX_POWER_DOWN)
			rdata_out <= tx_power_down_reg;
		else if (addr_in == `LLMC_ADDR_RX_POWER_DOWN)
			rdata_out <= rx_power_down_reg;
		else if (addr_in == `LLMC_ADDR_CHAN_STATE)
			rdata_out <= {transmit_all_ones, remote_loop};
		else
			rdata_out <= 8'h00;
	end
endmodule // llmc_loop_ctrl
